// *** sim/tb_usb_ep0_out_and_status_regs.sv ***
// Testbench: register, packet and event scenarios for the endpoint-0 block
`timescale 1ns/1ps

module tb_usb_ep0_out_and_status_regs;
    logic                  clk_sys, reset_n, func_reset, reg_wr, reg_rd, irq;
    logic [15:0]           reg_addr;
    logic [7:0]            reg_wdata, reg_rdata, b0;
    usb_ep0_pkg::usb_evt_t usb_evt;
    usb_ep0_pkg::hub_evt_t hub_evt;
    usb_ep0_pkg::reply_t   reply;
    usb_ep0_pkg::buf_wr_t  buf_wr;
    logic                  ep0_in_force_nak, p, tog;
    logic [6:0]            func_addr, fa;
    logic [3:0]            ep0_out_count, n;
    logic [2:0]            code;
    int                    err_count, n_tests, seed, i;

    usb_ep0_out_and_status_regs dut (.*);
    usb_host_model host (.clk_sys, .reply, .usb_evt);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Byte count register after an accepted packet
    function automatic logic [7:0] exp_bcnt(input logic [3:0] c);
        return {4'h8, c};
    endfunction
    // Reserved codes read as a full packet
    function automatic logic [7:0] exp_cnt(input logic [3:0] c);
        return (c > 4'h8) ? 8'h08 : {4'h0, c};
    endfunction

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_hs(input logic [2:0] got, input logic [2:0] exp);
        check("handshake", {5'h0, exp}, {5'h0, got});
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check(what, exp, reg_rdata);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog, the run needs about 600 cycles
    initial begin
        #50us;
        err_count++;
        test_done;
    end

    initial begin
        seed = 17;
        err_count = 0;
        n_tests = 0;
        {reset_n, func_reset, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        hub_evt = '0;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd_chk(usb_ep0_pkg::ADR_OUT_CFG, 8'h00, "cfg");
        rd_chk(usb_ep0_pkg::ADR_OUT_BCNT, 8'h80, "bcnt");
        rd_chk(usb_ep0_pkg::ADR_EV_STATUS, 8'h00, "status");
        rd_chk(usb_ep0_pkg::OUT_BUF_BASE, 8'h00, "unmapped");
        fa = 7'($random(seed)) | 7'h01;
        wr(usb_ep0_pkg::ADR_FUNC_ADDR, {1'b1, fa});
        rd_chk(usb_ep0_pkg::ADR_FUNC_ADDR, {1'b0, fa}, "addr");
        $display("test registers done");
        // Accepted packet, then a second one refused while buffer full
        wr(usb_ep0_pkg::ADR_OUT_CFG, 8'h84);
        wr(usb_ep0_pkg::ADR_OUT_BCNT, 8'h00);
        n = 4'($unsigned($random(seed)) % 9);
        host.out_pkt(fa, 1'b0, n, 1'b1, 8'h11, code);
        chk_hs(code, {1'b1, usb_ep0_pkg::HS_ACK});
        check("count", exp_cnt(n), {4'h0, ep0_out_count});
        check("irq", 8'h01, {7'h0, irq});
        rd_chk(usb_ep0_pkg::ADR_OUT_BCNT, exp_bcnt(n), "bcnt");
        rd_chk(usb_ep0_pkg::ADR_OUT_CFG, 8'hA4, "cfg");
        host.out_pkt(fa, 1'b1, 4'h2, 1'b1, 8'h22, code);
        chk_hs(code, {1'b1, usb_ep0_pkg::HS_NAK});
        wr(usb_ep0_pkg::ADR_EP0_EVENT, 8'h01);
        #1 check("irq", 8'h00, {7'h0, irq});
        // Completion with interrupt disabled, wrong address, bad CRC
        wr(usb_ep0_pkg::ADR_OUT_CFG, 8'h80);
        wr(usb_ep0_pkg::ADR_OUT_BCNT, 8'h00);
        host.out_pkt(fa, 1'b1, 4'h8, 1'b1, 8'h33, code);
        chk_hs(code, {1'b1, usb_ep0_pkg::HS_ACK});
        check("irq", 8'h00, {7'h0, irq});
        rd_chk(usb_ep0_pkg::ADR_OUT_CFG, 8'h80, "cfg");
        host.out_pkt(fa ^ 7'h01, 1'b0, 4'h1, 1'b1, 8'h44, code);
        chk_hs(code, 3'h0);
        $display("test packets done");
        for (i = 0; i < 16; i++) begin
            wr(usb_ep0_pkg::ADR_OUT_BCNT, 8'(i));
            @(posedge clk_sys);
            #1 check("count", exp_cnt(4'(i)), {4'h0, ep0_out_count});
        end
        host.out_pkt(fa, 1'b0, 4'h1, 1'b0, 8'h55, code);
        chk_hs(code, 3'h0);
        wr(usb_ep0_pkg::ADR_OUT_CFG, 8'h88);
        host.out_pkt(fa, 1'b0, 4'h1, 1'b1, 8'h66, code);
        chk_hs(code, {1'b1, usb_ep0_pkg::HS_STALL});
        rd_chk(usb_ep0_pkg::ADR_OUT_CFG, 8'h80, "cfg");
        wr(usb_ep0_pkg::ADR_OUT_CFG, 8'h00);
        host.out_pkt(fa, 1'b0, 4'h1, 1'b1, 8'h77, code);
        chk_hs(code, 3'h0);
        $display("test counts and stall done");
        // Setup blocks the endpoint; a second one overwrites
        wr(usb_ep0_pkg::ADR_OUT_CFG, 8'h80);
        host.setup_pkt(fa);
        rd_chk(usb_ep0_pkg::ADR_EV_STATUS, 8'h04, "status");
        host.out_pkt(fa, 1'b1, 4'h1, 1'b1, 8'h88, code);
        chk_hs(code, {1'b1, usb_ep0_pkg::HS_NAK});
        host.setup_pkt(fa);
        wr(usb_ep0_pkg::ADR_EV_STATUS, 8'h00);
        rd_chk(usb_ep0_pkg::ADR_EV_STATUS, 8'h05, "status");
        wr(usb_ep0_pkg::ADR_EV_STATUS, 8'h05);
        rd_chk(usb_ep0_pkg::ADR_EV_STATUS, 8'h00, "status");
        // Hub events one by one; function reset rides on the last
        for (i = 0; i < 5; i++) begin
            wr(usb_ep0_pkg::ADR_EV_MASK, 8'h00);
            hub_evt <= 5'h10 >> i;
            @(posedge clk_sys);
            hub_evt <= '0;
            func_reset <= (i == 4);
            @(posedge clk_sys);
            func_reset <= 1'b0;
            #1 check("irq", 8'h00, {7'h0, irq});
            rd_chk(usb_ep0_pkg::ADR_EV_STATUS, 8'h08 << i, "status");
            wr(usb_ep0_pkg::ADR_EV_MASK, 8'h08 << i);
            #1 check("irq", 8'h01, {7'h0, irq});
            wr(usb_ep0_pkg::ADR_EV_STATUS, 8'h08 << i);
            #1 check("irq", 8'h00, {7'h0, irq});
        end
        $display("test events done");
        // Random addresses, lengths, payloads and data toggles
        tog = 1'b0;
        wr(usb_ep0_pkg::ADR_OUT_CFG, 8'h80);
        repeat (24) begin
            fa = 7'($random(seed));
            n = 4'($unsigned($random(seed)) % 9);
            p = 1'($random(seed));
            b0 = 8'($random(seed));
            wr(usb_ep0_pkg::ADR_FUNC_ADDR, {1'b0, fa});
            wr(usb_ep0_pkg::ADR_OUT_BCNT, 8'h00);
            host.out_pkt(fa, p, n, 1'b1, b0, code);
            chk_hs(code, {1'b1, usb_ep0_pkg::HS_ACK});
            rd_chk(usb_ep0_pkg::ADR_OUT_BCNT, (p == tog) ? exp_bcnt(n) : 8'h00, "bcnt");
            if (p == tog) tog = ~tog;
            rd_chk(usb_ep0_pkg::ADR_OUT_CFG, {2'b10, tog, 5'h00}, "cfg");
        end
        $display("test random done");
        test_done;
    end
endmodule // tb_usb_ep0_out_and_status_regs

// *** sim/usb_ep0_out_and_status_regs_checker.sv ***
// Checker: port-level properties of the endpoint-0 register block
`timescale 1ns/1ps

module usb_ep0_out_and_status_regs_checker (
    // Clock and resets
    input wire logic                   clk_sys,
    input wire logic                   reset_n,
    input wire logic                   func_reset,
    // Register port
    input wire logic [15:0]            reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    // Link side and state
    input wire usb_ep0_pkg::usb_evt_t  usb_evt,
    input wire usb_ep0_pkg::hub_evt_t  hub_evt,
    input wire usb_ep0_pkg::reply_t    reply,
    input wire usb_ep0_pkg::buf_wr_t   buf_wr,
    input wire logic                   ep0_in_force_nak,
    input wire logic [6:0]             func_addr,
    input wire logic [3:0]             ep0_out_count,
    input wire logic                   irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Setup aimed at us, not racing a function reset
    wire own_setup = usb_evt.setup_tok && usb_evt.tok_addr == func_addr
                     && usb_evt.tok_ep == usb_ep0_pkg::EP0 && !func_reset;
    wire clr_setup = reg_wr && reg_addr == usb_ep0_pkg::ADR_EV_STATUS && reg_wdata[2];

    property p_count_sat; ep0_out_count <= usb_ep0_pkg::MAX_PKT; endproperty
    a_count_sat: assert property (p_count_sat)
        else $error("count view above eight");
    property p_buf_base; buf_wr.we |-> buf_wr.addr >= usb_ep0_pkg::OUT_BUF_BASE
        && buf_wr.addr < usb_ep0_pkg::OUT_BUF_BASE + 16'h0008; endproperty
    a_buf_base: assert property (p_buf_base)
        else $error("buffer write outside output buffer");
    property p_buf_data;
        buf_wr.we |-> $past(usb_evt.rx_valid) && buf_wr.data == $past(usb_evt.rx_byte);
    endproperty
    a_buf_data: assert property (p_buf_data)
        else $error("buffer write not from received byte");
    property p_reply_time; reply.valid |-> $past(usb_evt.data_end); endproperty
    a_reply_time: assert property (p_reply_time)
        else $error("handshake not one cycle after packet end");
    property p_fa_reset; func_reset |=> func_addr == usb_ep0_pkg::FA_RESET; endproperty
    a_fa_reset: assert property (p_fa_reset)
        else $error("address survived function reset");
    property p_setup_nak; own_setup |=> ep0_in_force_nak; endproperty
    a_setup_nak: assert property (p_setup_nak)
        else $error("setup did not raise forced nak");
    property p_setup_block;
        ep0_in_force_nak && reply.valid |-> reply.code != usb_ep0_pkg::HS_ACK;
    endproperty
    a_setup_block: assert property (p_setup_block)
        else $error("ack given while setup pending");
    property p_flag_w1c; $fell(ep0_in_force_nak) |-> $past(clr_setup); endproperty
    a_flag_w1c: assert property (p_flag_w1c)
        else $error("setup flag dropped without write one");
    property p_irq_drop; $fell(irq) |-> $past(reg_wr || func_reset); endproperty
    a_irq_drop: assert property (p_irq_drop)
        else $error("interrupt dropped with no write");

    // Main scenarios reached
    c_ack: cover property (reply.valid && reply.code == usb_ep0_pkg::HS_ACK);
    c_stall: cover property (reply.valid && reply.code == usb_ep0_pkg::HS_STALL);
    c_irq: cover property ($rose(irq));
endmodule // usb_ep0_out_and_status_regs_checker

bind usb_ep0_out_and_status_regs usb_ep0_out_and_status_regs_checker chk (.*);

// *** sim/usb_host_model.sv ***
// Host-side model: sends tokens and data packets, collects the handshake
`timescale 1ns/1ps

module usb_host_model (
    // Clock
    input  wire logic                 clk_sys,
    // Handshake from the device
    input  wire usb_ep0_pkg::reply_t  reply,
    // Token and data stream
    output usb_ep0_pkg::usb_evt_t     usb_evt
);
    initial usb_evt = '0;

    // OUT transaction; code[2] flags a handshake
    task automatic out_pkt(input logic [6:0] a, input logic p1, input logic [3:0] n,
                           input logic crc, input logic [7:0] b0, output logic [2:0] code);
        int k;
        @(posedge clk_sys);
        usb_evt.out_tok   <= 1'b1;
        usb_evt.tok_addr  <= a;
        usb_evt.tok_ep    <= usb_ep0_pkg::EP0;
        usb_evt.data_pid1 <= p1;
        for (k = 0; k < n; k++) begin
            @(posedge clk_sys);
            usb_evt.out_tok  <= 1'b0;
            usb_evt.tok_addr <= ~a;
            usb_evt.rx_valid <= 1'b1;
            usb_evt.rx_byte  <= b0 + 8'(k) * 8'h3B;
        end
        // Released lines flip so a stale value never looks valid
        @(posedge clk_sys);
        usb_evt.out_tok  <= 1'b0;
        usb_evt.tok_addr <= ~a;
        usb_evt.rx_valid <= 1'b0;
        usb_evt.rx_byte  <= ~usb_evt.rx_byte;
        usb_evt.data_end <= 1'b1;
        usb_evt.crc_ok   <= crc;
        @(posedge clk_sys);
        usb_evt.data_end <= 1'b0;
        usb_evt.crc_ok   <= ~crc;
        #1 code = reply.valid ? {1'b1, reply.code} : 3'h0;
        // Next token only after the handshake slot
        @(posedge clk_sys);
    endtask

    // Setup token to endpoint zero
    task automatic setup_pkt(input logic [6:0] a);
        @(posedge clk_sys);
        usb_evt.setup_tok <= 1'b1;
        usb_evt.tok_addr  <= a;
        usb_evt.tok_ep    <= usb_ep0_pkg::EP0;
        @(posedge clk_sys);
        usb_evt.setup_tok <= 1'b0;
        usb_evt.tok_addr  <= ~a;
    endtask
endmodule // usb_host_model

// *** verilog/event_flags.sv ***
// Sticky event flags: hardware sets, write-one clears, set wins
`timescale 1ns/1ps

module event_flags #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    // Set and clear vectors
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clear,
    // Flag state
    output logic      [W-1:0] flags
);

    // One flop per flag, a set in the clearing cycle survives
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_flag
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    flags[i] <= 1'b0;
                end else if (set[i]) begin
                    flags[i] <= 1'b1;
                end else if (clear[i]) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule // event_flags

// *** verilog/usb_ep0_out_and_status_regs.sv ***
// Endpoint-0 output registers, function address and event status logic
`timescale 1ns/1ps

module usb_ep0_out_and_status_regs (
    // Clock and resets
    input  wire logic                    clk_sys,
    input  wire logic                    reset_n,
    input  wire logic                    func_reset,
    // Firmware register port
    input  wire logic [15:0]             reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    // Serial engine and hub events
    input  wire usb_ep0_pkg::usb_evt_t   usb_evt,
    input  wire usb_ep0_pkg::hub_evt_t   hub_evt,
    // Handshake and buffer writes
    output usb_ep0_pkg::reply_t          reply,
    output usb_ep0_pkg::buf_wr_t         buf_wr,
    output logic                         ep0_in_force_nak,
    // Firmware-visible state
    output logic [usb_ep0_pkg::FA_W-1:0] func_addr,
    output logic [usb_ep0_pkg::CNT_W-1:0] ep0_out_count,
    output logic                         irq
);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_DATA  = 3'b010,
        ST_REPLY = 3'b100
    } state_t;

    // Saturate a byte count code at one full packet
    function automatic logic [usb_ep0_pkg::CNT_W-1:0] eff_count(
        input logic [usb_ep0_pkg::CNT_W-1:0] c
    );
        eff_count = (c > usb_ep0_pkg::MAX_PKT) ? usb_ep0_pkg::MAX_PKT : c;
    endfunction

    state_t                          state;
    state_t                          next_state;
    logic                            bme;
    logic                            stall;
    logic                            irq_en;
    logic                            toggle;
    logic                            nak;
    logic [usb_ep0_pkg::CNT_W-1:0]   bcnt;
    logic [7:0]                      ev_mask;
    logic [usb_ep0_pkg::CNT_W-1:0]   byte_idx;
    logic [7:0]                      ev_status;
    logic [0:0]                      ep0_done;
    logic                            next_bme;
    logic                            next_stall;
    logic                            next_irq_en;
    logic                            next_toggle;
    logic                            next_nak;
    logic [usb_ep0_pkg::CNT_W-1:0]   next_bcnt;
    logic [usb_ep0_pkg::FA_W-1:0]    next_func_addr;

    // Register port decode
    wire wr_cfg    = reg_wr && (reg_addr == usb_ep0_pkg::ADR_OUT_CFG);
    wire wr_bcnt   = reg_wr && (reg_addr == usb_ep0_pkg::ADR_OUT_BCNT);
    wire wr_fa     = reg_wr && (reg_addr == usb_ep0_pkg::ADR_FUNC_ADDR);
    wire wr_status = reg_wr && (reg_addr == usb_ep0_pkg::ADR_EV_STATUS);
    wire wr_mask   = reg_wr && (reg_addr == usb_ep0_pkg::ADR_EV_MASK);
    wire wr_ep0ev  = reg_wr && (reg_addr == usb_ep0_pkg::ADR_EP0_EVENT);

    // Token decode against our address and endpoint 0
    wire addr_hit  = (usb_evt.tok_addr == func_addr)
                     && (usb_evt.tok_ep == usb_ep0_pkg::EP0);
    wire out_hit   = usb_evt.out_tok && addr_hit;
    wire setup_hit = usb_evt.setup_tok && addr_hit;
    wire setup_flag = ev_status[usb_ep0_pkg::ST_SETUP];

    // Packet end decisions, only meaningful in ST_DATA
    wire pkt_end   = (state == ST_DATA) && usb_evt.data_end;
    wire pkt_stall = pkt_end && stall;
    wire pkt_good  = pkt_end && !stall && usb_evt.crc_ok;
    wire pkt_nak   = pkt_good && (nak || setup_flag);
    wire pkt_fresh = usb_evt.data_pid1 == toggle;
    wire pkt_take  = pkt_good && !nak && !setup_flag && pkt_fresh;
    wire pkt_ack   = pkt_good && !nak && !setup_flag;

    // Bytes land in the buffer only if the packet may be taken
    wire may_store = !stall && !nak && !setup_flag && pkt_fresh;
    wire byte_wr   = (state == ST_DATA) && usb_evt.rx_valid && may_store
                     && (byte_idx < usb_ep0_pkg::MAX_PKT);

    // Event status set and clear vectors
    wire [7:0] ev_set;
    assign ev_set[usb_ep0_pkg::ST_SETUP_OVERWRITE_FLAG] = setup_hit && setup_flag;
    assign ev_set[1]                     = 1'b0;
    assign ev_set[usb_ep0_pkg::ST_SETUP] = setup_hit;
    assign ev_set[usb_ep0_pkg::ST_PORT_POWER_ON_FLAG]  = hub_evt.pwr_on;
    assign ev_set[usb_ep0_pkg::ST_PORT_POWER_OFF_FLAG] = hub_evt.pwr_off;
    assign ev_set[usb_ep0_pkg::ST_FUNCTION_RESUME_FLAG]  = hub_evt.resume;
    assign ev_set[usb_ep0_pkg::ST_FUNCTION_SUSPEND_FLAG]  = hub_evt.suspend;
    assign ev_set[usb_ep0_pkg::ST_FUNCTION_RESET_FLAG]  = hub_evt.port_reset;

    // Writing zero leaves a flag alone; reserved bit cannot clear
    wire [7:0] ev_clr = wr_status ? (reg_wdata & usb_ep0_pkg::ST_USED)
                                  : 8'h00;

    // Function reset deliberately does not reach these flags
    event_flags #(
        .W (8)
    ) u_status (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .set     (ev_set),
        .clear   (ev_clr),
        .flags   (ev_status)
    );

    // Completion event, cleared by writing one to bit 0
    event_flags #(
        .W (1)
    ) u_done (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .set     (pkt_take),
        .clear   (wr_ep0ev && reg_wdata[0]),
        .flags   (ep0_done)
    );

    // Level interrupt: masked status plus gated completion
    assign irq = |(ev_status & ev_mask)
                 || (ep0_done[0] && irq_en);

    // Setup pending holds off IN traffic on endpoint 0 as well
    assign ep0_in_force_nak = setup_flag;

    // Configuration next values, hardware events beat firmware writes
    always_comb begin
        next_bme       = bme;
        next_stall     = stall;
        next_irq_en    = irq_en;
        next_toggle    = toggle;
        next_nak       = nak;
        next_bcnt      = bcnt;
        next_func_addr = func_addr;
        if (wr_cfg) begin
            next_bme    = reg_wdata[usb_ep0_pkg::CFG_BME];
            next_stall  = reg_wdata[usb_ep0_pkg::CFG_STALL];
            next_irq_en = reg_wdata[usb_ep0_pkg::CFG_IRQ_EN];
        end
        if (wr_bcnt) begin
            next_nak  = reg_wdata[usb_ep0_pkg::BCNT_NAK];
            next_bcnt = reg_wdata[usb_ep0_pkg::CNT_W-1:0];
        end
        if (wr_fa) begin
            next_func_addr = reg_wdata[usb_ep0_pkg::FA_W-1:0];
        end
        if (pkt_stall) begin
            next_stall = 1'b0;
        end
        if (setup_hit) begin
            next_toggle = 1'b1;
        end
        if (pkt_take) begin
            next_bcnt   = eff_count(byte_idx);
            next_nak    = 1'b1;
            next_toggle = !toggle;
        end
    end

    // Endpoint registers, USB function reset returns them to defaults
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bme       <= usb_ep0_pkg::CFG_RESET[usb_ep0_pkg::CFG_BME];
            stall     <= usb_ep0_pkg::CFG_RESET[usb_ep0_pkg::CFG_STALL];
            irq_en    <= usb_ep0_pkg::CFG_RESET[usb_ep0_pkg::CFG_IRQ_EN];
            toggle    <= usb_ep0_pkg::CFG_RESET[usb_ep0_pkg::CFG_TOGGLE];
            nak       <= usb_ep0_pkg::BCNT_RESET[usb_ep0_pkg::BCNT_NAK];
            bcnt      <= usb_ep0_pkg::BCNT_RESET[usb_ep0_pkg::CNT_W-1:0];
            func_addr <= usb_ep0_pkg::FA_RESET;
        end else if (func_reset) begin
            bme       <= usb_ep0_pkg::CFG_RESET[usb_ep0_pkg::CFG_BME];
            stall     <= usb_ep0_pkg::CFG_RESET[usb_ep0_pkg::CFG_STALL];
            irq_en    <= usb_ep0_pkg::CFG_RESET[usb_ep0_pkg::CFG_IRQ_EN];
            toggle    <= usb_ep0_pkg::CFG_RESET[usb_ep0_pkg::CFG_TOGGLE];
            nak       <= usb_ep0_pkg::BCNT_RESET[usb_ep0_pkg::BCNT_NAK];
            bcnt      <= usb_ep0_pkg::BCNT_RESET[usb_ep0_pkg::CNT_W-1:0];
            func_addr <= usb_ep0_pkg::FA_RESET;
        end else begin
            bme       <= next_bme;
            stall     <= next_stall;
            irq_en    <= next_irq_en;
            toggle    <= next_toggle;
            nak       <= next_nak;
            bcnt      <= next_bcnt;
            func_addr <= next_func_addr;
        end
    end

    // Mask survives function reset, only power-up clears it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ev_mask <= usb_ep0_pkg::MASK_RESET;
        end else if (wr_mask) begin
            ev_mask <= reg_wdata & usb_ep0_pkg::ST_USED;
        end
    end

    // Effective count for the firmware copy loop
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ep0_out_count <= '0;
        end else begin
            ep0_out_count <= eff_count(next_bcnt);
        end
    end

    // Transaction sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (out_hit && bme) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (func_reset) begin
                    next_state = ST_IDLE;
                end else if (pkt_stall || pkt_nak || pkt_ack) begin
                    next_state = ST_REPLY;
                end else if (pkt_end) begin
                    next_state = ST_IDLE;                            // Bad CRC, stay mute
                end
            end
            ST_REPLY: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Byte index within the current packet, saturates at a full packet
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            byte_idx <= '0;
        end else if (state == ST_IDLE) begin
            byte_idx <= '0;
        end else if ((state == ST_DATA) && usb_evt.rx_valid
                     && (byte_idx < usb_ep0_pkg::MAX_PKT)) begin
            byte_idx <= byte_idx + 4'h1;
        end
    end

    // Handshake answer, one cycle after the packet end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reply <= '0;
        end else begin
            reply.valid <= pkt_stall || pkt_nak || pkt_ack;
            if (pkt_stall) begin
                reply.code <= usb_ep0_pkg::HS_STALL;
            end else if (pkt_nak) begin
                reply.code <= usb_ep0_pkg::HS_NAK;
            end else if (pkt_ack) begin
                reply.code <= usb_ep0_pkg::HS_ACK;
            end else begin
                reply.code <= 2'h0;
            end
        end
    end

    // Buffer writes, offset from the fixed output base
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            buf_wr <= '0;
        end else begin
            buf_wr.we   <= byte_wr;
            buf_wr.addr <= usb_ep0_pkg::OUT_BUF_BASE
                           + {12'h000, byte_idx};
            buf_wr.data <= usb_evt.rx_byte;
        end
    end

    // Read multiplexer, reserved bits read zero
    wire [7:0] cfg_view = {bme, 1'b0, toggle, 1'b0, stall, irq_en, 2'b00};
    wire [7:0] bcnt_view = {nak, 3'b000, bcnt};
    wire [7:0] rd_mux =
        (reg_addr == usb_ep0_pkg::ADR_OUT_CFG)   ? cfg_view :
        (reg_addr == usb_ep0_pkg::ADR_OUT_BCNT)  ? bcnt_view :
        (reg_addr == usb_ep0_pkg::ADR_FUNC_ADDR) ? {1'b0, func_addr} :
        (reg_addr == usb_ep0_pkg::ADR_EV_STATUS) ? ev_status :
        (reg_addr == usb_ep0_pkg::ADR_EV_MASK)   ? ev_mask :
        (reg_addr == usb_ep0_pkg::ADR_EP0_EVENT) ? {7'h00, ep0_done} :
        8'h00;

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

endmodule // usb_ep0_out_and_status_regs

// *** verilog/usb_ep0_pkg.sv ***
// Package: register map, field positions, handshake codes and carriers
package usb_ep0_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int FA_W   = 7;
    localparam int CNT_W  = 4;
    localparam int EP_W   = 4;

    // Register addresses on the firmware port
    localparam logic [15:0] ADR_OUT_BCNT  = 16'hFF83;
    localparam logic [15:0] ADR_OUT_CFG   = 16'hFF82;
    localparam logic [15:0] ADR_EP0_EVENT = 16'hFF84;
    localparam logic [15:0] ADR_EV_STATUS = 16'hFF91;
    localparam logic [15:0] ADR_EV_MASK   = 16'hFF92;
    localparam logic [15:0] ADR_FUNC_ADDR = 16'hFF93;

    // Fixed packet buffer bases, no base register exists
    localparam logic [15:0] OUT_BUF_BASE = 16'hFEF0;
    localparam logic [15:0] IN_BUF_BASE  = 16'hFEF8;

    // Configuration register fields
    localparam int CFG_BME    = 7;
    localparam int CFG_TOGGLE = 5;
    localparam int CFG_STALL  = 3;
    localparam int CFG_IRQ_EN = 2;

    // Byte count register fields
    localparam int BCNT_NAK = 7;
    localparam logic [CNT_W-1:0] MAX_PKT = 4'h8;

    // Event status / mask bit positions
    localparam int ST_SETUP_OVERWRITE_FLAG = 0;
    localparam int ST_SETUP = 2;
    localparam int ST_PORT_POWER_ON_FLAG  = 3;
    localparam int ST_PORT_POWER_OFF_FLAG = 4;
    localparam int ST_FUNCTION_RESUME_FLAG  = 5;
    localparam int ST_FUNCTION_SUSPEND_FLAG  = 6;
    localparam int ST_FUNCTION_RESET_FLAG  = 7;
    localparam logic [7:0] ST_USED = 8'hFD;

    // Reset values
    localparam logic [7:0]      CFG_RESET  = 8'h00;
    localparam logic [7:0]      BCNT_RESET = 8'h80;
    localparam logic [7:0]      MASK_RESET = 8'h00;
    localparam logic [FA_W-1:0] FA_RESET   = 7'h00;
    localparam logic [EP_W-1:0] EP0        = 4'h0;

    // Handshake codes
    localparam logic [1:0] HS_ACK   = 2'h1;
    localparam logic [1:0] HS_NAK   = 2'h2;
    localparam logic [1:0] HS_STALL = 2'h3;

    // Events from the serial interface engine
    typedef struct packed {
        logic            out_tok;
        logic            setup_tok;
        logic [FA_W-1:0] tok_addr;
        logic [EP_W-1:0] tok_ep;
        logic            rx_valid;
        logic [7:0]      rx_byte;
        logic            data_end;
        logic            crc_ok;
        logic            data_pid1;
    } usb_evt_t;

    // Hub-side events toward the embedded function
    typedef struct packed {
        logic pwr_on;
        logic pwr_off;
        logic resume;
        logic suspend;
        logic port_reset;
    } hub_evt_t;

    // Handshake answer toward the serial engine
    typedef struct packed {
        logic       valid;
        logic [1:0] code;
    } reply_t;

    // Packet buffer write port
    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  data;
    } buf_wr_t;

endpackage
